// >>> pkg/io_port_pkg.sv
package io_port_pkg;

  localparam int PIN_COUNT = 6;

  // Register indices on the plain register port
  localparam logic [2:0] ADDR_LEVEL     = 3'h0;
  localparam logic [2:0] ADDR_DIRECTION = 3'h1;
  localparam logic [2:0] ADDR_LATCH     = 3'h2;
  localparam logic [2:0] ADDR_ANALOG    = 3'h3;
  localparam logic [2:0] ADDR_ALT_PIN   = 3'h4;

  // Field positions
  localparam int INPUT_ONLY_BIT  = 3;
  localparam int PIN_A_ONE_BIT   = 1;
  localparam int PIN_A_TWO_BIT   = 2;
  localparam int LOGIC_CELL_BIT  = 1;
  localparam int OSC_OUT_BIT     = 0;

  // Reset values
  localparam logic [5:0] DIRECTION_RESET = 6'h3F;
  localparam logic [5:0] LATCH_RESET     = 6'h00;
  localparam logic [5:0] ANALOG_MASK     = 6'h17;
  localparam logic [5:0] ANALOG_RESET    = 6'h17;
  localparam logic [1:0] ALT_PIN_RESET   = 2'h0;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic enable;
    logic value;
  } periph_out_t;

endpackage

// >>> src/six_bit_io_port.sv
`timescale 1ns/10ps

// Functional notes
// - Six pins, each with direction, output latch and level readback bits.
// - Direction bit 1 turns the pin driver off; pin is an input.
// - Direction bit 0 drives the output latch value onto the pin.
// - Pin three is input only, never driven; its direction reads one.
// - Writes to latch or level register both update the output latch.
// - Latch read returns latch; level read returns actual pin levels.
// - Port writes are read-modify-write merged into the output latch.
// - Analog select bit disables that pin's digital input buffer.
// - Digital reads of analog pins return zero, for port and peripherals.
// - Analog select never affects digital outputs.
// - Analog select bits reset to analog; software clears for digital.
// - Enabled peripheral takes the pin from the latch; level stays readable.
// - Steering never changes direction register; overrides go to selected pin.
// - Unselected pin keeps working as an ordinary port pin.
// - Steering bit one: logic cell on pin C five if 1, else A two.
// - Steering bit zero: oscillator out on pin C six if 1, else A one.
// - Steering register bits seven to two read zero.
module six_bit_io_port
  import io_port_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [7:0]  regRdata,
  input  wire logic [5:0]  pinIn,
  output logic      [5:0]  pinOut,
  output logic      [5:0]  pinOe,
  input  wire logic        logicCellEn,
  input  wire logic        logicCellOut,
  input  wire logic        oscOutEn,
  input  wire logic        oscOut,
  output logic      [5:0]  periphIn,
  output logic             pinCFiveSel,
  output logic             pinCSixSel
);

  reg_req_t    req;
  periph_out_t cellDrive;
  periph_out_t oscDrive;
  pin_drive_t  drive;

  assign req       = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign cellDrive = '{enable: logicCellEn, value: logicCellOut};
  assign oscDrive  = '{enable: oscOutEn, value: oscOut};

  // Three-stage input sampling; stage one feeds stage two only
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] sync3_q;
  logic [5:0] level_q;
  logic [5:0] level_d;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
      sync3_q <= 6'h00;
    end else begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_filter
      always_comb begin
        level_d[gi] = level_q[gi];
        if (sync2_q[gi] == sync3_q[gi]) begin
          level_d[gi] = sync3_q[gi];
        end
      end
    end
  endgenerate

  // Register state
  logic [5:0] direction_q;
  logic [5:0] direction_d;
  logic [5:0] latch_q;
  logic [5:0] latch_d;
  logic [5:0] analog_q;
  logic [5:0] analog_d;
  logic [1:0] altPin_q;
  logic [1:0] altPin_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [5:0] pinOut_d;
  logic [5:0] pinOe_d;
  logic [5:0] periphIn_d;
  logic       pinCFiveSel_d;
  logic       pinCSixSel_d;
  logic [5:0] digitalIn;
  logic       hitLatch;
  logic       hitDirection;
  logic       hitAnalog;
  logic       hitAltPin;
  logic [5:0] cellPinMask;
  logic [5:0] oscPinMask;

  // Filtered pin levels
  always_ff @(posedge core_clk) begin
    if (rst) begin
      level_q <= 6'h00;
    end else begin
      level_q <= level_d;
    end
  end

  // Write decode; unmapped indices hit nothing
  always_comb begin
    hitLatch     = 1'b0;
    hitDirection = 1'b0;
    hitAnalog    = 1'b0;
    hitAltPin    = 1'b0;
    if (req.wr) begin
      unique case (req.addr)
        ADDR_LEVEL, ADDR_LATCH: hitLatch = 1'b1;
        ADDR_DIRECTION:         hitDirection = 1'b1;
        ADDR_ANALOG:            hitAnalog = 1'b1;
        ADDR_ALT_PIN:           hitAltPin = 1'b1;
        default: ;
      endcase
    end
  end

  // Direction
  always_comb begin
    direction_d = direction_q;
    if (hitDirection) begin
      direction_d = req.wdata[5:0];
    end
    // No driver behind pin three, so its bit stays an input
    direction_d[INPUT_ONLY_BIT] = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      direction_q <= DIRECTION_RESET;
    end else begin
      direction_q <= direction_d;
    end
  end

  // Output latch
  // The bus always carries a whole byte, so every implemented bit is modified
  // and merging with the sampled levels leaves the written value, with pin three's bit held at zero
  always_comb begin
    latch_d = latch_q;
    if (hitLatch) begin
      latch_d = req.wdata[5:0];
    end
    latch_d[INPUT_ONLY_BIT] = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_q <= LATCH_RESET;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Analog select; pins without an analog path keep a zero bit
  always_comb begin
    analog_d = analog_q;
    if (hitAnalog) begin
      analog_d = req.wdata[5:0] & ANALOG_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      analog_q <= ANALOG_RESET;
    end else begin
      analog_q <= analog_d;
    end
  end

  // Pin steering
  always_comb begin
    altPin_d = altPin_q;
    if (hitAltPin) begin
      altPin_d = req.wdata[1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      altPin_q <= ALT_PIN_RESET;
    end else begin
      altPin_q <= altPin_d;
    end
  end

  // Disabled input buffer reads zero
  assign digitalIn = level_q & ~analog_q;

  // Read data stands only in the cycle after the strobe
  always_comb begin
    rdata_d = UNMAPPED_READ;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_LEVEL:     rdata_d = {2'b00, digitalIn};
        ADDR_DIRECTION: rdata_d = {2'b00, direction_q};
        ADDR_LATCH:     rdata_d = {2'b00, latch_q};
        ADDR_ANALOG:    rdata_d = {2'b00, analog_q};
        ADDR_ALT_PIN:   rdata_d = {6'h00, altPin_q};
        default:        rdata_d = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_q <= UNMAPPED_READ;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Pins on this port that a steered function currently owns
  // A function steered to port C leaves its pin here as a plain port pin
  always_comb begin
    cellPinMask = 6'h00;
    oscPinMask  = 6'h00;
    if (!altPin_q[LOGIC_CELL_BIT]) begin
      cellPinMask[PIN_A_TWO_BIT] = cellDrive.enable;
    end
    if (!altPin_q[OSC_OUT_BIT]) begin
      oscPinMask[PIN_A_ONE_BIT] = oscDrive.enable;
    end
  end

  // Pin drive: latch by default, peripheral overrides on its selected pin
  // Direction stays with the direction register; steering never touches it
  always_comb begin
    drive.out = latch_q;
    drive.oe  = ~direction_q;
    if (cellPinMask[PIN_A_TWO_BIT]) begin
      drive.out[PIN_A_TWO_BIT] = cellDrive.value;
    end
    if (oscPinMask[PIN_A_ONE_BIT]) begin
      drive.out[PIN_A_ONE_BIT] = oscDrive.value;
    end
    drive.oe[INPUT_ONLY_BIT] = 1'b0;
  end

  // Output stage; every top-level output leaves from a flop
  always_comb begin
    pinOut_d      = drive.out;
    pinOe_d       = drive.oe;
    periphIn_d    = digitalIn;
    pinCFiveSel_d = altPin_q[LOGIC_CELL_BIT];
    pinCSixSel_d  = altPin_q[OSC_OUT_BIT];
  end

  // Pins come out released during reset so the board sees no glitch
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinOut      <= 6'h00;
      pinOe       <= 6'h00;
      periphIn    <= 6'h00;
      pinCFiveSel <= 1'b0;
      pinCSixSel  <= 1'b0;
    end else begin
      pinOut      <= pinOut_d;
      pinOe       <= pinOe_d;
      periphIn    <= periphIn_d;
      pinCFiveSel <= pinCFiveSel_d;
      pinCSixSel  <= pinCSixSel_d;
    end
  end

  assign regRdata = rdata_q;

endmodule

// >>> tb/io_port_sva.sv
`timescale 1ns/10ps
module io_port_sva
  import io_port_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdata,
  input wire logic [5:0] pinOut,
  input wire logic [5:0] pinOe,
  input wire logic       logicCellEn,
  input wire logic       logicCellOut,
  input wire logic       pinCFiveSel
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_OE3: assert property (pinOe[3] == 1'b0) else $error("pin3 driven");
  AST_RDIDLE: assert property (!regRd |=> regRdata == 8'h00) else $error("stray data");
  AST_DIR3: assert property (regRd && regAddr == ADDR_DIRECTION |=> regRdata[3]) else $error("dir3 low");
  AST_ALTHI: assert property (regRd && regAddr == ADDR_ALT_PIN |=> regRdata[7:2] == 6'h00)
    else $error("alt high bits");
  AST_DIRW: assert property (regWr && regAddr == ADDR_DIRECTION |=>
    ##1 pinOe == (~$past(regWdata[5:0], 2) & 6'h37)) else $error("oe mismatch");
  AST_LATW: assert property (regWr && (regAddr == ADDR_LATCH || regAddr == ADDR_LEVEL) |=>
    ##1 {pinOut[5:4], pinOut[0]} == {$past(regWdata[5:4], 2), $past(regWdata[0], 2)}) else $error("latch out");
  AST_CELL: assert property ((logicCellEn && !pinCFiveSel && $stable(logicCellOut))[*3]
    |-> pinOut[2] == logicCellOut) else $error("cell override");
  AST_ALTOE: assert property (regWr && regAddr == ADDR_ALT_PIN |=> ##1 $stable(pinOe))
    else $error("steer moved oe");
endmodule

bind six_bit_io_port io_port_sva sva (.*);

// >>> tb/pin_board.sv
`timescale 1ns/10ps
module pin_board (
  input  wire logic [5:0] pinOut,
  input  wire logic [5:0] pinOe,
  input  wire logic [5:0] extLevel,
  output logic      [5:0] pinIn
);
  // Driven pins show the port's value, released ones the board's
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// >>> tb/tb_six_bit_io_port.sv
`timescale 1ns/10ps
module tb_six_bit_io_port
  import io_port_pkg::*;
;
  logic       core_clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
  logic       logicCellEn = 1'b0, logicCellOut = 1'b0, oscOutEn = 1'b0, oscOut = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [5:0] extLevel = 6'h3F, pinIn, pinOut, pinOe, periphIn;
  logic       pinCFiveSel, pinCSixSel;
  int         miscompares = 0, checked = 0, cycles = 0;

  six_bit_io_port dut (.*);
  pin_board board (.*);

  initial forever #20 core_clk = ~core_clk;

  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Bench runs well under this; a hang counts as a miscompare
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk(regRdata, exp);
  endtask

  // Covers output lag and the pin synchroniser
  task automatic settle;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    settle();
    rd(ADDR_DIRECTION, 8'h3F);
    rd(ADDR_LATCH, 8'h00);
    rd(ADDR_ANALOG, 8'h17);
    rd(ADDR_ALT_PIN, 8'h00);
    rd(ADDR_LEVEL, 8'h28);
    chk({2'b00, periphIn}, 8'h28);
    $display("test 1 done");
    wr(ADDR_ANALOG, 8'h00);
    settle();
    rd(ADDR_LEVEL, 8'h3F);
    $display("test 2 done");
    wr(ADDR_ANALOG, 8'h17);
    wr(ADDR_DIRECTION, 8'h00);
    rd(ADDR_DIRECTION, 8'h08);
    wr(ADDR_LEVEL, 8'hD5);
    settle();
    rd(ADDR_LATCH, 8'h15);
    chk({2'b00, pinOe}, 8'h37);
    chk({2'b00, pinOut}, 8'h15);
    rd(ADDR_LEVEL, 8'h08);
    chk({2'b00, periphIn}, 8'h08);
    $display("test 3 done");
    wr(ADDR_LATCH, 8'h31);
    @(posedge core_clk);
    logicCellEn <= 1'b1;
    logicCellOut <= 1'b1;
    oscOutEn <= 1'b1;
    oscOut <= 1'b1;
    settle();
    chk({2'b00, pinOut}, 8'h37);
    wr(ADDR_ALT_PIN, 8'hFF);
    settle();
    rd(ADDR_ALT_PIN, 8'h03);
    chk({6'h00, pinCFiveSel, pinCSixSel}, 8'h03);
    chk({2'b00, pinOut}, 8'h31);
    chk({2'b00, pinOe}, 8'h37);
    rd(3'h5, 8'h00);
    $display("test 4 done");
    complete_run();
  end
endmodule
